// *** bench/adc_input_timing_asserts.sv ***
// Port-level assertions for the input select and stage timing block
`timescale 1ns/1ps
`default_nettype none
module adc_input_timing_asserts
  import adc_timing_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [5:0]  neg_mux_sel,
  input wire logic [2:0]  stage_status,
  input wire logic        conv_done
);
  logic [13:0] conv_len;
  logic [5:0]  wdat_low;
  assign wdat_low = wb_dat_i[5:0];
  // Counts conversion cycles so the exit check sees the whole stage
  always_ff @(posedge core_clk)
  begin
    if (!nrst || stage_status != STAGE_CONV)
      conv_len <= 14'h0000;
    else
      conv_len <= conv_len + 14'h0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_exit;
    $past(stage_status) == STAGE_CONV && stage_status != STAGE_CONV;
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("No ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack longer than one cycle");
  a_read_bytes: assert property
    (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("Read data above byte lane");
  a_stage_legal: assert property (stage_status <= STAGE_CONV)
    else $error("Illegal stage code");
  a_stage_fwd: assert property
    (($changed(stage_status) && stage_status != 3'h0)
    |-> stage_status > $past(stage_status)) else $error("Stage order broken");
  a_done_exit: assert property
    (s_exit |-> conv_done && stage_status == 3'h0)
    else $error("Conversion end not flagged");
  a_conv_full: assert property (s_exit |-> conv_len >= CONV_TICKS)
    else $error("Conversion stage too short");
  a_sel_copy: assert property
    ((wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
    && wb_sel_i[0] && wb_adr_i[15:2] == IDX_NEG_INPUT) |=> ##1
    neg_mux_sel == $past(wdat_low, 2)) else $error("Select copy wrong");
endmodule
bind adc_input_timing adc_input_timing_asserts u_chk (.core_clk, .nrst,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .neg_mux_sel, .stage_status, .conv_done);
`default_nettype wire

// *** bench/adc_input_timing_bench.sv ***
// Self-checking bench for the input select and stage timing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin failures++; \
  $display("MISMATCH at %0t: got %0h want %0h", $time, g, w); end end
module adc_input_timing_bench
  import adc_timing_pkg::*;
;
  localparam logic [31:0] PINS  = 32'h004A_556A;
  localparam logic [31:0] LARGE = 32'hAC00_0000;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        large_package = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [5:0]  neg_mux_sel;
  logic        neg_mux_en;
  logic [2:0]  stage_status;
  logic        conv_done;
  logic [7:0]  q;
  int          failures = 0;
  int          n_checks = 0;
  int          cnt [4];
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (stage_status inside {[3'h1:3'h3]})
      cnt[stage_status] += 1;
  adc_input_timing dut (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .large_package,
    .neg_mux_sel, .neg_mux_en, .stage_status, .conv_done);
  function automatic logic exp_en(input logic [5:0] c, input logic lg);
    return c >= 6'h3A || (c == 6'h21 && lg) ||
      (!c[5] && (PINS[c[4:0]] || (lg && LARGE[c[4:0]])));
  endfunction
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // No fixed latency assumed; a wait ends on ack or at the 50-cycle bound
  task automatic wb(input logic we, input logic [13:0] idx,
    input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      failures++;
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_reset();
    logic [13:0] idx [6];
    idx = '{IDX_NEG_INPUT, IDX_ACQ_LO, IDX_ACQ_HI, IDX_PRE_LO, IDX_PRE_HI,
      IDX_STATUS};
    `CHK(neg_mux_en, 1'b0)
    foreach (idx[i])
    begin
      wb(1'b0, idx[i], 8'h00);
      `CHK(q, 8'h00)
    end
  endtask
  task automatic t_bytes();
    wb(1'b1, IDX_PRE_HI, 8'hFF);
    wb(1'b0, IDX_PRE_HI, 8'h00);
    `CHK(q, 8'h1F)
    wb(1'b1, IDX_ACQ_HI, 8'hEA);
    wb(1'b1, IDX_ACQ_LO, 8'hA5);
    wb(1'b0, IDX_ACQ_HI, 8'h00);
    `CHK(q, 8'h0A)
    wb(1'b0, IDX_ACQ_LO, 8'h00);
    `CHK(q, 8'hA5)
    wb(1'b1, 14'h1D30, 8'hFF);
    wb(1'b0, 14'h1D30, 8'h00);
    `CHK(q, 8'h00)
  endtask
  task automatic t_channels();
    for (int lg = 0; lg < 2; lg++)
    begin
      large_package <= lg[0];
      for (int c = 0; c < 64; c++)
      begin
        wb(1'b1, IDX_NEG_INPUT, 8'(c));
        @(posedge core_clk);
        `CHK(neg_mux_sel, 6'(c))
        `CHK(neg_mux_en, exp_en(6'(c), lg[0]))
        wb(1'b0, IDX_NEG_INPUT, 8'h00);
        `CHK(q, 8'(c))
      end
    end
  endtask
  task automatic t_seq(input logic [12:0] p, input logic [12:0] a,
    input logic cs, input int l1, h1, l2, h2, l3, h3);
    int n;
    wb(1'b1, IDX_PRE_LO, p[7:0]);
    wb(1'b1, IDX_PRE_HI, {3'h0, p[12:8]});
    wb(1'b1, IDX_ACQ_LO, a[7:0]);
    wb(1'b1, IDX_ACQ_HI, {3'h0, a[12:8]});
    wb(1'b1, IDX_CONTROL, {6'h00, cs, 1'b0});
    cnt = '{default: 0};
    wb(1'b1, IDX_CONTROL, {6'h00, cs, 1'b1});
    n = 0;
    while (conv_done !== 1'b1 && n < 20000)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK(n < 20000, 1'b1)
    `CHK(cnt[1] inside {[l1:h1]}, 1'b1)
    `CHK(cnt[2] inside {[l2:h2]}, 1'b1)
    `CHK(cnt[3] inside {[l3:h3]}, 1'b1)
    wb(1'b0, IDX_CONTROL, 8'h00);
    `CHK(q[0], 1'b0)
    wb(1'b0, IDX_STATUS, 8'h00);
    `CHK(q[2:0], STAGE_IDLE)
  endtask
  // Reset in mid-sample must drop the stage and clear the registers
  task automatic t_midreset();
    wb(1'b1, IDX_PRE_LO, 8'h40);
    wb(1'b1, IDX_CONTROL, 8'h01);
    repeat (4) @(posedge core_clk);
    `CHK(stage_status, STAGE_PRE)
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    `CHK(stage_status, STAGE_IDLE)
    `CHK(conv_done, 1'b0)
    `CHK(neg_mux_sel, 6'h00)
    wb(1'b0, IDX_PRE_LO, 8'h00);
    `CHK(q, 8'h00)
    wb(1'b0, IDX_NEG_INPUT, 8'h00);
    `CHK(q, 8'h00)
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_bytes();
    t_channels();
    t_seq(13'h0003, 13'h0005, 1'b0, 3, 3, 5, 5, 16, 16);
    t_seq(13'h0000, 13'h0000, 1'b0, 0, 0, 0, 0, 16, 16);
    t_seq(13'h0000, 13'h0004, 1'b0, 0, 0, 4, 4, 16, 16);
    t_seq(13'h0002, 13'h0000, 1'b0, 2, 2, 8192, 8192, 16, 16);
    // RC ticks are free running, so only a window is known
    t_seq(13'h0002, 13'h0001, 1'b1, 65, 128, 1, 64, 961, 1024);
    t_midreset();
    final_report();
  end
  initial
  begin
    repeat (40000) @(posedge core_clk);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire

// *** src/adc_input_timing.sv ***
// Negative input select, stage timing registers and stage sequencer
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module adc_input_timing
  import adc_timing_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        large_package,
  output logic      [5:0]  neg_mux_sel,
  output logic             neg_mux_en,
  output logic      [2:0]  stage_status,
  output logic             conv_done
);

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV} seq_state_e;

  stage_timing_if tim ();

  timing_tick_gen u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .t        (tim)
  );

  stage_timer u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .t        (tim)
  );

  logic [CHAN_W-1:0]  neg_chan_sel_reg;
  logic [COUNT_W-1:0] acquire_cycles_reg;
  logic [COUNT_W-1:0] precharge_cycles_reg;
  logic [CAP_W-1:0]   extra_cap_reg;
  logic               go_reg;
  logic               clk_src_reg;
  seq_state_e         state_reg;
  seq_state_e         state_next;
  logic [TIMER_W-1:0] load_val_next;
  logic               load_next;

  // Bus decode
  logic        bus_req;
  logic        wr_en;
  logic [13:0] reg_idx;
  logic        hit_neg;
  logic        hit_acq_lo;
  logic        hit_acq_hi;
  logic        hit_cap;
  logic        hit_pre_lo;
  logic        hit_pre_hi;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [7:0]  wr_byte;
  logic [7:0]  rd_byte;
  logic [2:0]  stage_code;
  logic [2:0]  stage_next_code;
  logic        wr_neg;
  logic        wr_acq_lo;
  logic        wr_acq_hi;
  logic        wr_cap;
  logic        wr_pre_lo;
  logic        wr_pre_hi;
  logic        wr_ctrl;

  assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en      = bus_req && wb_we_i && wb_sel_i[0];
  assign reg_idx    = wb_adr_i[15:2];
  assign wr_byte    = wb_dat_i[7:0];
  assign hit_neg    = (reg_idx == IDX_NEG_INPUT);
  assign hit_acq_lo = (reg_idx == IDX_ACQ_LO);
  assign hit_acq_hi = (reg_idx == IDX_ACQ_HI);
  assign hit_cap    = (reg_idx == IDX_EXTRA_CAP);
  assign hit_pre_lo = (reg_idx == IDX_PRE_LO);
  assign hit_pre_hi = (reg_idx == IDX_PRE_HI);
  assign hit_ctrl   = (reg_idx == IDX_CONTROL);
  assign hit_stat   = (reg_idx == IDX_STATUS);

  // Per-register write strobes keep the register blocks short
  assign wr_neg     = wr_en && hit_neg;
  assign wr_acq_lo  = wr_en && hit_acq_lo;
  assign wr_acq_hi  = wr_en && hit_acq_hi;
  assign wr_cap     = wr_en && hit_cap;
  assign wr_pre_lo  = wr_en && hit_pre_lo;
  assign wr_pre_hi  = wr_en && hit_pre_hi;
  assign wr_ctrl    = wr_en && hit_ctrl;

  // One encoding shared by the status read and the status output
  function automatic logic [2:0] stage_encode(input seq_state_e s);
    logic [2:0] code;
    code = STAGE_IDLE;
    unique case (s)
      ST_IDLE: code = STAGE_IDLE;
      ST_PRE:  code = STAGE_PRE;
      ST_ACQ:  code = STAGE_ACQ;
      ST_CONV: code = STAGE_CONV;
    endcase
    return code;
  endfunction

  assign stage_code      = stage_encode(state_reg);
  assign stage_next_code = stage_encode(state_next);

  // Unmapped indexes read as zero; upper word bits always zero
  assign rd_byte =
    hit_neg    ? {2'b00, neg_chan_sel_reg} :
    hit_acq_lo ? acquire_cycles_reg[7:0] :
    hit_acq_hi ? {3'b000, acquire_cycles_reg[12:8]} :
    hit_cap    ? {3'b000, extra_cap_reg} :
    hit_pre_lo ? precharge_cycles_reg[7:0] :
    hit_pre_hi ? {3'b000, precharge_cycles_reg[12:8]} :
    hit_ctrl   ? {6'b000000, clk_src_reg, go_reg} :
    hit_stat   ? {5'b00000, stage_code} :
                 8'h00;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      neg_chan_sel_reg <= NEG_CHAN_RESET;
    else if (wr_neg)
      neg_chan_sel_reg <= wr_byte[5:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      acquire_cycles_reg <= COUNT_RESET;
    else if (wr_acq_lo)
      acquire_cycles_reg[7:0] <= wr_byte;
    else if (wr_acq_hi)
      acquire_cycles_reg[12:8] <= wr_byte[HI_W-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      precharge_cycles_reg <= COUNT_RESET;
    else if (wr_pre_lo)
      precharge_cycles_reg[7:0] <= wr_byte;
    else if (wr_pre_hi)
      precharge_cycles_reg[12:8] <= wr_byte[HI_W-1:0];
  end

  // Capacitor value is only stored here; no output port carries it, only the bus read returns it
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      extra_cap_reg <= CAP_RESET;
    else if (wr_cap)
      extra_cap_reg <= wr_byte[CAP_W-1:0];
  end

  // Clock source changes mid-sample would stretch a stage; only when idle
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      clk_src_reg <= 1'b0;
    else if (wr_ctrl && state_reg == ST_IDLE)
      clk_src_reg <= wr_byte[CTRL_CS_BIT];
  end

  // Go stays high for the whole sample; hardware clears it at the end
  logic seq_finish;
  assign seq_finish = (state_reg == ST_CONV) && tim.done;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      go_reg <= 1'b0;
    else if (wr_ctrl && wr_byte[CTRL_GO_BIT])
      go_reg <= 1'b1;
    else if (seq_finish)
      go_reg <= 1'b0;
  end

  // Stage sequencer
  logic pre_zero;
  logic acq_zero;
  logic start;

  assign pre_zero = (precharge_cycles_reg == COUNT_RESET);
  assign acq_zero = (acquire_cycles_reg == COUNT_RESET);
  assign start    = go_reg && (state_reg == ST_IDLE) && !seq_finish;

  always_comb
  begin
    state_next    = state_reg;
    load_next     = 1'b0;
    load_val_next = CONV_TICKS;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (start && !pre_zero)
        begin
          state_next    = ST_PRE;
          load_next     = 1'b1;
          load_val_next = {1'b0, precharge_cycles_reg};
        end
        else if (start && !acq_zero)
        begin
          state_next    = ST_ACQ;
          load_next     = 1'b1;
          load_val_next = {1'b0, acquire_cycles_reg};
        end
        else if (start)
        begin
          state_next = ST_CONV;
          load_next  = 1'b1;
        end
      end
      ST_PRE:
      begin
        if (tim.done)
        begin
          state_next    = ST_ACQ;
          load_next     = 1'b1;
          load_val_next = acq_zero ? ACQ_ZERO_TICKS
                                   : {1'b0, acquire_cycles_reg};
        end
      end
      ST_ACQ:
      begin
        if (tim.done)
        begin
          state_next = ST_CONV;
          load_next  = 1'b1;
        end
      end
      ST_CONV:
      begin
        if (tim.done)
          state_next = ST_IDLE;
      end
    endcase
  end

  assign tim.load     = load_next;
  assign tim.load_val = load_val_next;
  assign tim.use_rc   = clk_src_reg;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Outputs registered
  logic nch_ok;
  assign nch_ok = neg_code_connects(neg_chan_sel_reg, large_package);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      neg_mux_sel  <= NEG_CHAN_RESET;
      neg_mux_en   <= 1'b0;
      stage_status <= STAGE_IDLE;
      conv_done    <= 1'b0;
    end
    else
    begin
      neg_mux_sel  <= neg_chan_sel_reg;
      neg_mux_en   <= nch_ok;
      stage_status <= stage_next_code;
      conv_done    <= seq_finish;
    end
  end
  // Reserved codes and large-package-only pins on a small package leave the mux disabled
  // Pin subset is held in the package decode function

endmodule
`default_nettype wire

// *** src/adc_timing_pkg.sv ***
// Constants, register map and decode helpers for the input/timing control
package adc_timing_pkg;

  localparam int unsigned CORE_CLK_HZ = 40000000;
  localparam int unsigned RC_CLK_HZ   = 625000;
  localparam logic [7:0]  RC_DIV_CYCLES = 8'(CORE_CLK_HZ / RC_CLK_HZ);

  // Printed offsets are register indexes; byte address is four times index
  localparam logic [13:0] IDX_NEG_INPUT  = 14'h1D20;
  localparam logic [13:0] IDX_ACQ_LO     = 14'h1D21;
  localparam logic [13:0] IDX_ACQ_HI     = 14'h1D22;
  localparam logic [13:0] IDX_EXTRA_CAP  = 14'h1D23;
  localparam logic [13:0] IDX_PRE_LO     = 14'h1D24;
  localparam logic [13:0] IDX_PRE_HI     = 14'h1D25;
  localparam logic [13:0] IDX_CONTROL    = 14'h1D26;
  localparam logic [13:0] IDX_STATUS     = 14'h1D27;

  localparam int unsigned CHAN_W  = 6;
  localparam int unsigned COUNT_W = 13;
  localparam int unsigned TIMER_W = 14;
  localparam int unsigned HI_W    = 5;
  localparam int unsigned CAP_W   = 5;

  localparam logic [CHAN_W-1:0]  NEG_CHAN_RESET = 6'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET    = 13'h0000;
  localparam logic [CAP_W-1:0]   CAP_RESET      = 5'h00;

  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_CS_BIT = 1;

  localparam logic [TIMER_W-1:0] ACQ_ZERO_TICKS = 14'h2000;
  localparam logic [TIMER_W-1:0] CONV_TICKS     = 14'h0010;

  localparam logic [2:0] STAGE_IDLE = 3'h0;
  localparam logic [2:0] STAGE_PRE  = 3'h1;
  localparam logic [2:0] STAGE_ACQ  = 3'h2;
  localparam logic [2:0] STAGE_CONV = 3'h3;

  localparam logic [CHAN_W-1:0] NCH_FIXED_REF2 = 6'h3F;
  localparam logic [CHAN_W-1:0] NCH_FIXED_REF1 = 6'h3E;
  localparam logic [CHAN_W-1:0] NCH_DAC2       = 6'h3D;
  localparam logic [CHAN_W-1:0] NCH_DAC1       = 6'h3C;
  localparam logic [CHAN_W-1:0] NCH_TEMP       = 6'h3B;
  localparam logic [CHAN_W-1:0] NCH_GROUND     = 6'h3A;
  localparam logic [CHAN_W-1:0] NCH_PORT_E1    = 6'h21;

  // Port pins A..D usable on the negative input, bit n set = code n
  localparam logic [31:0] NCH_PIN_MAP_ALL   = 32'h004A_556A;
  localparam logic [31:0] NCH_PIN_MAP_LARGE = 32'hAC00_0000;

  // True when the code routes a real source to the negative input
  function automatic logic neg_code_connects(input logic [CHAN_W-1:0] code,
                                             input logic large_pkg);
    logic pin_ok;
    pin_ok = NCH_PIN_MAP_ALL[code[4:0]] |
             (large_pkg & NCH_PIN_MAP_LARGE[code[4:0]]);
    if (code >= NCH_GROUND)
      return 1'b1;
    else if (code == NCH_PORT_E1)
      return large_pkg;
    else if (code[5])
      return 1'b0;
    else
      return pin_ok;
  endfunction

endpackage

// *** src/stage_timer.sv ***
// Down counter that times one stage in timing ticks
`timescale 1ns/1ps
`default_nettype none
module stage_timer
  import adc_timing_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   nrst,
  stage_timing_if.timer t
);

  logic [TIMER_W-1:0] cnt_reg;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else if (t.load)
      cnt_reg <= t.load_val;
    else if (t.tick && cnt_reg != '0)
      cnt_reg <= cnt_reg - 14'h0001;
  end

  // Done on the last tick so the next stage starts with no gap
  assign t.done = t.tick && (cnt_reg == 14'h0001);
endmodule
`default_nettype wire

// *** src/stage_timing_if.sv ***
// Signals shared by the tick divider, the stage timer and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface stage_timing_if;
  import adc_timing_pkg::*;
  logic               tick;
  logic               use_rc;
  logic               load;
  logic [TIMER_W-1:0] load_val;
  logic               done;

  modport divider (input use_rc, output tick);
  modport timer   (input tick, input load, input load_val, output done);
  modport control (input done, output use_rc, output load, output load_val);
endinterface
`default_nettype wire

// *** src/timing_tick_gen.sv ***
// Timing tick: every core cycle, or one per internal RC clock period
`timescale 1ns/1ps
`default_nettype none
module timing_tick_gen
  import adc_timing_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     nrst,
  stage_timing_if.divider t
);

  logic [7:0] div_reg;
  logic       wrap;

  assign wrap = (div_reg == RC_DIV_CYCLES - 8'h01);

  always_ff @(posedge core_clk)
  begin
    if (!nrst || !t.use_rc || wrap)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end

  // Oscillator source ticks every cycle; RC source once per divider wrap
  assign t.tick = !t.use_rc || wrap;
endmodule
`default_nettype wire
